// ---- rtl/pss_pkg.sv ----
// package: register map, bit layout and latch indices of the phy status summary block
package pss_pkg;
    // ------------------------------------------------------------
    // register addresses (management register index)
    // ------------------------------------------------------------
    localparam int PSS_AW = 5;
    localparam int PSS_DW = 16;
    localparam logic [4:0] PSS_ADDR_BASIC_STATUS = 5'h01;
    localparam logic [4:0] PSS_ADDR_AN_EXPANSION = 5'h06;
    localparam logic [4:0] PSS_ADDR_SUMMARY = 5'h10;
    localparam logic [4:0] PSS_ADDR_INT_STATUS_EVENT = 5'h12;
    localparam logic [4:0] PSS_ADDR_FALSE_CARRIER_CNT = 5'h14;
    localparam logic [4:0] PSS_ADDR_RX_ERROR_CNT = 5'h15;
    localparam logic [4:0] PSS_ADDR_PCS_CONFIG = 5'h16;
    localparam logic [4:0] PSS_ADDR_PHY_CONTROL = 5'h19;
    localparam logic [4:0] PSS_ADDR_TENMEG_STATUS = 5'h1a;
    localparam logic [4:0] PSS_ADDR_EVT_STATUS = 5'h1c;
    localparam logic [4:0] PSS_ADDR_EVT_MASK = 5'h1d;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PSS_SUM_RESERVED = 15;
    localparam int PSS_SUM_XOVER = 14;
    localparam int PSS_SUM_RXERR = 13;
    localparam int PSS_SUM_POLARITY = 12;
    localparam int PSS_SUM_FCARRIER = 11;
    localparam int PSS_SUM_SIGDET = 10;
    localparam int PSS_SUM_LOCK = 9;
    localparam int PSS_SUM_PAGE = 8;
    localparam int PSS_SUM_INTPEND = 7;
    localparam int PSS_SUM_RFAULT = 6;
    localparam int PSS_LOW_W = 6;
    localparam int PSS_CTL_AUTO_EN = 15;
    localparam int PSS_CTL_FORCE = 14;
    localparam int PSS_PCS_SD_QUALIFY = 8;
    localparam int PSS_TENMEG_POLARITY = 4;
    localparam int PSS_AUTONEG_EXPANSION_REGISTER_PAGE = 1;
    localparam int PSS_BASIC_RFAULT = 4;
    // ------------------------------------------------------------
    // latch indices and reset values
    // ------------------------------------------------------------
    localparam int PSS_NLAT = 8;
    localparam int PSS_L_RXERR = 0;
    localparam int PSS_L_POLARITY = 1;
    localparam int PSS_L_FCARRIER = 2;
    localparam int PSS_L_SIGDET = 3;
    localparam int PSS_L_LOCK = 4;
    localparam int PSS_L_PAGE = 5;
    localparam int PSS_L_INTPEND = 6;
    localparam int PSS_L_RFAULT = 7;
    localparam logic [7:0] PSS_LOW_MASK = 8'h18;
    localparam logic [7:0] PSS_LAT_RESET = 8'h00;
    localparam logic [15:0] PSS_WORD_RESET = 16'h0000;
    localparam logic [7:0] PSS_EVT_RESET = 8'h00;
endpackage : pss_pkg

// ---- rtl/pss_latch_if.sv ----
// interface: live inputs, read clears and held values of the status latches
`timescale 1ns/1ps
interface pss_latch_if #(parameter int N = 8);
    logic [N-1:0] live;
    logic [N-1:0] clr;
    logic [N-1:0] q;
    modport owner (input live, input clr, output q);
    modport user (output live, output clr, input q);
endinterface : pss_latch_if

// ---- rtl/pss_latch.sv ----
// status latch bank: latching-high and latching-low bits with read clear
`timescale 1ns/1ps
module pss_latch #(
    parameter int N = 8,
    parameter logic [N-1:0] LOW_MASK = '0,
    parameter logic [N-1:0] RESET_VAL = '0
) (
    input wire logic clk_i,          // core clock
    input wire logic rst_i,          // async reset, high
    pss_latch_if.owner lat           // live, clear and held values
);
    typedef struct packed {
        logic [N-1:0] q;
    } pss_lat_s;

    pss_lat_s cur;
    pss_lat_s next_cur;
    logic [N-1:0] next_q;

    // ------------------------------------------------------------
    // per-bit latch behaviour
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_bit
            if (LOW_MASK[g]) begin : g_low
                // a read reloads the live level; until then a low stays caught
                assign next_q[g] = lat.clr[g] ? lat.live[g] : (cur.q[g] & lat.live[g]);
            end else begin : g_high
                // set wins over a clear arriving in the same cycle
                assign next_q[g] = lat.live[g] | (cur.q[g] & ~lat.clr[g]);
            end
        end
    endgenerate

    always_comb begin
        next_cur = cur;
        next_cur.q = next_q;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cur.q <= RESET_VAL;
        end else begin
            cur <= next_cur;
        end
    end

    assign lat.q = cur.q;

    AST_SET_WINS: assert property (@(posedge clk_i) disable iff (rst_i)
        (lat.live & ~LOW_MASK) != '0 |=> (cur.q & $past(lat.live & ~LOW_MASK)) != '0)
        else $error("latch set lost against clear");
endmodule : pss_latch

// ---- rtl/pss_top.sv ----
// phy status summary word, bits 15 to 6, with its latches, controls and event interrupt
//
// Summary of operation
// R1: bit 15 reserved, reads zero, writes ignored
// R2: bit 14 reports crossover, one means swapped
// R3: crossover follows enable and force, live when auto
// R4: bit 13 latches receive error, cleared by 15h read
// R5: bit 12 mirrors polarity, cleared by its register
// R6: bit 11 latches false carrier, cleared by 14h read
// R7: bit 10 latching-low qualified signal detect
// R8: bit 9 latching-low descrambler lock
// R9: bit 8 mirrors page received, cleared by 06h
// R10: bit 7 interrupt pending, cleared by 12h read
// R11: bit 6 remote fault, cleared by 01h read
// R12: bits 5..0 join into one 16-bit word
`timescale 1ns/1ps
module pss_top
    import pss_pkg::*;
(
    input wire logic REF_CLK_I,                         // 200 MHz core clock
    input wire logic RST_I,                             // async reset, high
    input wire logic [pss_pkg::PSS_AW-1:0] ADDR_I,      // register index
    input wire logic [pss_pkg::PSS_DW-1:0] WDATA_I,     // write data
    input wire logic WR_I,                              // write strobe
    input wire logic RD_I,                              // read strobe
    output logic [pss_pkg::PSS_DW-1:0] RDATA_O,         // read data, cycle after strobe
    input wire logic XOVER_ALG_SWAP_I,                  // auto crossover algorithm state
    input wire logic RX_ERROR_I,                        // receive error event
    input wire logic FALSE_CARRIER_I,                   // false carrier event
    input wire logic POLARITY_INVERTED_I,               // inverted polarity detected
    input wire logic RAW_SIGNAL_DETECT_I,               // raw signal detect
    input wire logic DESCRAMBLER_LOCK_I,                // descrambler locked
    input wire logic PAGE_RECEIVED_I,                   // link code word page received
    input wire logic INTERRUPT_EVENT_I,                 // internal interrupt raised
    input wire logic REMOTE_FAULT_I,                    // partner remote fault
    input wire logic [pss_pkg::PSS_LOW_W-1:0] LOW_STATUS_I, // bits 5..0 of the word
    output logic CROSSOVER_O,                           // pairs swapped
    output logic IRQ_O                                  // level interrupt
);
    import pss_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [PSS_DW-1:0] rdata;
        logic auto_en;
        logic force_x;
        logic sd_qualify;
        logic xover;
        logic [PSS_NLAT-1:0] evt_mask;
        logic [PSS_NLAT-1:0] evt_status;
    } pss_state_s;

    pss_state_s cur;
    pss_state_s next_cur;

    pss_latch_if #(.N(PSS_NLAT)) lat ();

    logic rd_sum;
    logic rd_basic;
    logic rd_autoneg_expansion_register;
    logic rd_interrupt_status_event_register;
    logic rd_fcar;
    logic rd_rxerr;
    logic rd_tenmeg;
    logic rd_evt;
    logic sd_qualified;
    logic [PSS_NLAT-1:0] events;
    logic [PSS_DW-1:0] summary;

    // ------------------------------------------------------------
    // read decode: reads of the owning registers clear the mirrors
    // ------------------------------------------------------------
    assign rd_sum = RD_I && (ADDR_I == PSS_ADDR_SUMMARY);
    assign rd_basic = RD_I && (ADDR_I == PSS_ADDR_BASIC_STATUS);
    assign rd_autoneg_expansion_register = RD_I && (ADDR_I == PSS_ADDR_AN_EXPANSION);
    assign rd_interrupt_status_event_register = RD_I && (ADDR_I == PSS_ADDR_INT_STATUS_EVENT);
    assign rd_fcar = RD_I && (ADDR_I == PSS_ADDR_FALSE_CARRIER_CNT);
    assign rd_rxerr = RD_I && (ADDR_I == PSS_ADDR_RX_ERROR_CNT);
    assign rd_tenmeg = RD_I && (ADDR_I == PSS_ADDR_TENMEG_STATUS);
    assign rd_evt = RD_I && (ADDR_I == PSS_ADDR_EVT_STATUS);

    // qualification by lock is optional so a slow-locking link can still be seen
    assign sd_qualified = cur.sd_qualify ? (RAW_SIGNAL_DETECT_I & DESCRAMBLER_LOCK_I)
                                         : RAW_SIGNAL_DETECT_I; // R7

    // ------------------------------------------------------------
    // latch bank hookup
    // ------------------------------------------------------------
    always_comb begin
        lat.live = '0;
        lat.clr = '0;
        lat.live[PSS_L_RXERR] = RX_ERROR_I; // R4
        lat.clr[PSS_L_RXERR] = rd_rxerr; // R4
        lat.live[PSS_L_POLARITY] = POLARITY_INVERTED_I; // R5
        lat.clr[PSS_L_POLARITY] = rd_tenmeg; // R5
        lat.live[PSS_L_FCARRIER] = FALSE_CARRIER_I; // R6
        lat.clr[PSS_L_FCARRIER] = rd_fcar; // R6
        lat.live[PSS_L_SIGDET] = sd_qualified; // R7
        lat.clr[PSS_L_SIGDET] = rd_sum; // R7
        lat.live[PSS_L_LOCK] = DESCRAMBLER_LOCK_I; // R8
        lat.clr[PSS_L_LOCK] = rd_sum; // R8
        lat.live[PSS_L_PAGE] = PAGE_RECEIVED_I; // R9
        lat.clr[PSS_L_PAGE] = rd_autoneg_expansion_register; // R9
        lat.live[PSS_L_INTPEND] = INTERRUPT_EVENT_I; // R10
        lat.clr[PSS_L_INTPEND] = rd_interrupt_status_event_register; // R10
        lat.live[PSS_L_RFAULT] = REMOTE_FAULT_I; // R11
        lat.clr[PSS_L_RFAULT] = rd_basic; // R11
    end

    pss_latch #(
        .N(PSS_NLAT),
        .LOW_MASK(PSS_LOW_MASK),
        .RESET_VAL(PSS_LAT_RESET)
    ) u_latch (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .lat(lat)
    );

    // an event is the active level of each source: high, or low for the latching-low bits
    assign events = lat.live ^ PSS_LOW_MASK;

    // ------------------------------------------------------------
    // summary word assembly
    // ------------------------------------------------------------
    always_comb begin
        summary = PSS_WORD_RESET;
        summary[PSS_LOW_W-1:0] = LOW_STATUS_I; // R12
        summary[PSS_SUM_RESERVED] = 1'b0; // R1
        summary[PSS_SUM_XOVER] = cur.xover; // R2
        summary[PSS_SUM_RXERR] = lat.q[PSS_L_RXERR]; // R4
        summary[PSS_SUM_POLARITY] = lat.q[PSS_L_POLARITY]; // R5
        summary[PSS_SUM_FCARRIER] = lat.q[PSS_L_FCARRIER]; // R6
        summary[PSS_SUM_SIGDET] = lat.q[PSS_L_SIGDET]; // R7
        summary[PSS_SUM_LOCK] = lat.q[PSS_L_LOCK]; // R8
        summary[PSS_SUM_PAGE] = lat.q[PSS_L_PAGE]; // R9
        summary[PSS_SUM_INTPEND] = lat.q[PSS_L_INTPEND]; // R10
        summary[PSS_SUM_RFAULT] = lat.q[PSS_L_RFAULT]; // R11
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        // crossover: force wins, else live algorithm when auto, else normal pairs
        if (cur.force_x) begin
            next_cur.xover = 1'b1; // R3
        end else if (cur.auto_en) begin
            next_cur.xover = XOVER_ALG_SWAP_I; // R3
        end else begin
            next_cur.xover = 1'b0; // R3
        end
        // write port; the summary word itself takes no writes
        if (WR_I) begin
            case (ADDR_I)
                PSS_ADDR_PHY_CONTROL: begin
                    next_cur.auto_en = WDATA_I[PSS_CTL_AUTO_EN];
                    next_cur.force_x = WDATA_I[PSS_CTL_FORCE];
                end
                PSS_ADDR_PCS_CONFIG: begin
                    next_cur.sd_qualify = WDATA_I[PSS_PCS_SD_QUALIFY];
                end
                PSS_ADDR_EVT_MASK: begin
                    next_cur.evt_mask = WDATA_I[PSS_NLAT-1:0];
                end
                default: begin
                    next_cur.auto_en = cur.auto_en; // R1
                end
            endcase
        end
        // sticky events: read clears, a new event in the same cycle survives
        next_cur.evt_status = (cur.evt_status & ~{PSS_NLAT{rd_evt}}) | events;
        // read port: unmapped indices and 12h, 14h, 15h answer zero
        next_cur.rdata = PSS_WORD_RESET;
        if (RD_I) begin
            case (ADDR_I)
                PSS_ADDR_SUMMARY: begin
                    next_cur.rdata = summary; // R12
                end
                PSS_ADDR_PHY_CONTROL: begin
                    next_cur.rdata[PSS_CTL_AUTO_EN] = cur.auto_en;
                    next_cur.rdata[PSS_CTL_FORCE] = cur.force_x;
                end
                PSS_ADDR_PCS_CONFIG: begin
                    next_cur.rdata[PSS_PCS_SD_QUALIFY] = cur.sd_qualify;
                end
                PSS_ADDR_TENMEG_STATUS: begin
                    next_cur.rdata[PSS_TENMEG_POLARITY] = lat.q[PSS_L_POLARITY];
                end
                PSS_ADDR_AN_EXPANSION: begin
                    next_cur.rdata[PSS_AUTONEG_EXPANSION_REGISTER_PAGE] = lat.q[PSS_L_PAGE];
                end
                PSS_ADDR_BASIC_STATUS: begin
                    next_cur.rdata[PSS_BASIC_RFAULT] = lat.q[PSS_L_RFAULT];
                end
                PSS_ADDR_EVT_STATUS: begin
                    next_cur.rdata[PSS_NLAT-1:0] = cur.evt_status;
                end
                PSS_ADDR_EVT_MASK: begin
                    next_cur.rdata[PSS_NLAT-1:0] = cur.evt_mask;
                end
                default: begin
                    next_cur.rdata = PSS_WORD_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cur.rdata <= PSS_WORD_RESET;
            cur.auto_en <= 1'b0;
            cur.force_x <= 1'b0;
            cur.sd_qualify <= 1'b0;
            cur.xover <= 1'b0;
            cur.evt_mask <= PSS_EVT_RESET;
            cur.evt_status <= PSS_EVT_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    assign RDATA_O = cur.rdata;
    assign CROSSOVER_O = cur.xover;
    assign IRQ_O = |(cur.evt_status & cur.evt_mask);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);

    sequence s_force_written;
        WR_I && ADDR_I == PSS_ADDR_PHY_CONTROL && WDATA_I[PSS_CTL_FORCE];
    endsequence

    sequence s_summary_read;
        RD_I && ADDR_I == PSS_ADDR_SUMMARY;
    endsequence

    AST_RESERVED_ZERO: assert property (s_summary_read |=> !RDATA_O[PSS_SUM_RESERVED]) // R1
        else $error("reserved summary bit read as one");

    AST_FORCE_SWAPS: assert property (s_force_written |=> ##1 CROSSOVER_O) // R3
        else $error("forced crossover not reported");

    AST_XOVER_REPORTED: assert property (s_summary_read // R2
        |=> RDATA_O[PSS_SUM_XOVER] == $past(cur.xover))
        else $error("crossover bit differs from crossover state");

    AST_AUTO_LIVE: assert property (cur.auto_en && !cur.force_x // R3
        && !(WR_I && ADDR_I == PSS_ADDR_PHY_CONTROL)
        |=> CROSSOVER_O == $past(XOVER_ALG_SWAP_I))
        else $error("auto crossover does not follow algorithm");

    // with both controls off the pairs must come back to normal orientation
    AST_XOVER_NORMAL: assert property (!cur.force_x && !cur.auto_en |=> !CROSSOVER_O) // R3
        else $error("crossover reported with crossover disabled");

    AST_RXERR_HOLD: assert property (lat.q[PSS_L_RXERR] && !rd_rxerr |=> lat.q[PSS_L_RXERR]) // R4
        else $error("receive error latch dropped without its read");

    AST_RXERR_CLEAR: assert property (rd_rxerr && !RX_ERROR_I |=> !lat.q[PSS_L_RXERR]) // R4
        else $error("receive error latch not cleared by counter read");

    AST_POL_SURVIVES_SUMMARY: assert property ((s_summary_read and lat.q[PSS_L_POLARITY]) // R5
        |=> lat.q[PSS_L_POLARITY] && RDATA_O[PSS_SUM_POLARITY])
        else $error("polarity mirror cleared by summary read");

    AST_FCAR_CAUGHT: assert property (FALSE_CARRIER_I // R6
        |=> lat.q[PSS_L_FCARRIER] [*1] ##1 (lat.q[PSS_L_FCARRIER] || $past(rd_fcar)))
        else $error("false carrier event lost");

    AST_SD_LATCH_LOW: assert property (!sd_qualified ##1 !rd_sum |=> !lat.q[PSS_L_SIGDET]) // R7
        else $error("signal detect low not held");

    // a summary read is what re-arms the latching-low bit from the live level
    AST_SIGDET_RELOAD: assert property ((s_summary_read and sd_qualified) // R7
        |=> lat.q[PSS_L_SIGDET])
        else $error("signal detect not reloaded by summary read");

    AST_LOCK_LATCH_LOW: assert property (!DESCRAMBLER_LOCK_I |=> !lat.q[PSS_L_LOCK]) // R8
        else $error("descrambler lock loss not caught");

    AST_PAGE_CLEAR: assert property (rd_autoneg_expansion_register && !PAGE_RECEIVED_I |=> !lat.q[PSS_L_PAGE]) // R9
        else $error("page received not cleared by expansion read");

    AST_PAGE_SURVIVES_SUMMARY: assert property ((s_summary_read and lat.q[PSS_L_PAGE]) // R9
        |=> lat.q[PSS_L_PAGE])
        else $error("page received mirror cleared by summary read");

    AST_INTPEND_CLEAR: assert property (lat.q[PSS_L_INTPEND] && rd_interrupt_status_event_register && !INTERRUPT_EVENT_I // R10
        |=> !RDATA_O[PSS_SUM_INTPEND] && !lat.q[PSS_L_INTPEND])
        else $error("pending interrupt not cleared by its status read");

    AST_RFAULT_CLEAR: assert property (rd_basic && !REMOTE_FAULT_I |=> !lat.q[PSS_L_RFAULT]) // R11
        else $error("remote fault not cleared by basic status read");

    AST_RFAULT_SET: assert property (REMOTE_FAULT_I |=> lat.q[PSS_L_RFAULT]) // R11
        else $error("remote fault not caught");

    AST_LOW_BITS_JOINED: assert property (s_summary_read // R12
        |=> RDATA_O[PSS_LOW_W-1:0] == $past(LOW_STATUS_I))
        else $error("low status bits not joined into word");

    // read data stand for one cycle only, so a late sampler sees zero, not stale data
    AST_RDATA_IDLE: assert property (!RD_I |=> RDATA_O == PSS_WORD_RESET)
        else $error("read data present without a read strobe");

    AST_EVT_CAUGHT: assert property (events != '0
        |=> (cur.evt_status & $past(events)) == $past(events))
        else $error("event not held in event status");
endmodule : pss_top

// ---- test/pss_sta_model.sv ----
// partner model: station management master issuing register reads and writes
`timescale 1ns/1ps
module pss_sta_model
    import pss_pkg::*;
(
    input wire logic clk_i,                          // core clock
    output logic [pss_pkg::PSS_AW-1:0] addr_o,       // register index
    output logic [pss_pkg::PSS_DW-1:0] wdata_o,      // write data
    output logic wr_o,                               // write strobe
    output logic rd_o,                               // read strobe
    input wire logic [pss_pkg::PSS_DW-1:0] rdata_i   // read data
);
    initial begin
        addr_o = '0;
        wdata_o = '0;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // ------------------------------------------------------------
    // bus cycles: one-cycle strobes, never together
    // ------------------------------------------------------------
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= v;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        // stale data would hide a slave that samples late
        wdata_o <= ~v;
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1;
        v = rdata_i;
    endtask : rd
endmodule : pss_sta_model

// ---- test/pss_top_tb.sv ----
// testbench: register sequences against the phy status summary block
`timescale 1ns/1ps
module pss_top_tb;
    import pss_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] addr;
    logic [15:0] wdata, rdata, d, base;
    logic wr, rd, xover, irq;
    logic swap = 1'b0;
    logic sd = 1'b1;
    logic lock = 1'b1;
    logic [7:0] evt = 8'h00;
    int failures = 0;
    int check_count = 0;
    int lat_ix[6] = '{PSS_L_RXERR, PSS_L_POLARITY, PSS_L_FCARRIER, PSS_L_PAGE,
                      PSS_L_INTPEND, PSS_L_RFAULT};
    int sum_bit[6] = '{13, 12, 11, 8, 7, 6};
    logic [4:0] clr_addr[6] = '{PSS_ADDR_RX_ERROR_CNT, PSS_ADDR_TENMEG_STATUS,
        PSS_ADDR_FALSE_CARRIER_CNT, PSS_ADDR_AN_EXPANSION, PSS_ADDR_INT_STATUS_EVENT,
        PSS_ADDR_BASIC_STATUS};
    // counter contents at 14h/15h are not modelled, so entries 0 and 2 go unchecked
    logic [15:0] clr_data[6] = '{16'h0000, 16'h0010, 16'h0000, 16'h0002, 16'h0000, 16'h0010};

    always #2.5 clk = ~clk;

    pss_top u_dut (.REF_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .XOVER_ALG_SWAP_I(swap), .RX_ERROR_I(evt[PSS_L_RXERR]),
        .FALSE_CARRIER_I(evt[PSS_L_FCARRIER]), .POLARITY_INVERTED_I(evt[PSS_L_POLARITY]),
        .RAW_SIGNAL_DETECT_I(sd), .DESCRAMBLER_LOCK_I(lock), .PAGE_RECEIVED_I(evt[PSS_L_PAGE]),
        .INTERRUPT_EVENT_I(evt[PSS_L_INTPEND]), .REMOTE_FAULT_I(evt[PSS_L_RFAULT]),
        .LOW_STATUS_I(6'h2a), .CROSSOVER_O(xover), .IRQ_O(irq));

    pss_sta_model u_sta (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
        .rdata_i(rdata));

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        u_sta.rd(a, d);
        chk_word(d, exp);
    endtask : rd_chk

    task automatic pulse_evt(input int i);
        @(posedge clk);
        evt[i] <= 1'b1;
        @(posedge clk);
        evt[i] <= 1'b0;
    endtask : pulse_evt

    task automatic drop(input bit use_sd);
        @(posedge clk);
        if (use_sd) sd <= 1'b0;
        else lock <= 1'b0;
        @(posedge clk);
        sd <= 1'b1;
        lock <= 1'b1;
    endtask : drop

    task automatic xover_chk(input logic exp);
        repeat (3) @(posedge clk);
        #1;
        chk_bit(xover, exp);
    endtask : xover_chk

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk(PSS_ADDR_SUMMARY, 16'h002a);
        base = 16'h062a;
        rd_chk(PSS_ADDR_SUMMARY, base);
        u_sta.wr(PSS_ADDR_SUMMARY, 16'hffff);
        rd_chk(PSS_ADDR_SUMMARY, base);
        rd_chk(5'h1f, 16'h0000);
        u_sta.wr(PSS_ADDR_PHY_CONTROL, 16'h4000);
        xover_chk(1'b1);
        rd_chk(PSS_ADDR_SUMMARY, base | 16'h4000);
        u_sta.wr(PSS_ADDR_PHY_CONTROL, 16'h8000);
        for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            swap <= v[0];
            xover_chk(v[0]);
        end
        rd_chk(PSS_ADDR_SUMMARY, base | 16'h4000);
        u_sta.wr(PSS_ADDR_PHY_CONTROL, 16'h0000);
        xover_chk(1'b0);
        for (int i = 0; i < 6; i++) begin
            pulse_evt(lat_ix[i]);
            rd_chk(PSS_ADDR_SUMMARY, base | (16'h0001 << sum_bit[i]));
            rd_chk(PSS_ADDR_SUMMARY, base | (16'h0001 << sum_bit[i]));
            u_sta.rd(clr_addr[i], d);
            if (i != 0 && i != 2) chk_word(d, clr_data[i]);
            rd_chk(PSS_ADDR_SUMMARY, base);
        end
        chk_bit(irq, 1'b0);
        rd_chk(PSS_ADDR_EVT_STATUS, 16'h00e7);
        rd_chk(PSS_ADDR_EVT_STATUS, 16'h0000);
        drop(1'b0);
        rd_chk(PSS_ADDR_SUMMARY, base & 16'hfdff);
        rd_chk(PSS_ADDR_SUMMARY, base);
        drop(1'b1);
        rd_chk(PSS_ADDR_SUMMARY, base & 16'hfbff);
        u_sta.wr(PSS_ADDR_PCS_CONFIG, 16'h0100);
        drop(1'b0);
        rd_chk(PSS_ADDR_SUMMARY, base & 16'hf9ff);
        rd_chk(PSS_ADDR_SUMMARY, base);
        u_sta.rd(PSS_ADDR_EVT_STATUS, d);
        u_sta.wr(PSS_ADDR_EVT_MASK, 16'h0001);
        rd_chk(PSS_ADDR_EVT_MASK, 16'h0001);
        chk_bit(irq, 1'b0);
        pulse_evt(PSS_L_RXERR);
        #1;
        chk_bit(irq, 1'b1);
        rd_chk(PSS_ADDR_EVT_STATUS, 16'h0001);
        chk_bit(irq, 1'b0);
        rd_chk(PSS_ADDR_SUMMARY, base | 16'h2000);
        test_done;
    end

    // the whole sequence needs about 130 cycles; this leaves ample margin
    initial begin
        #100000;
        failures++;
        test_done;
    end
endmodule : pss_top_tb
